// ===== rtl/cmc_regs.svh
// Purpose: named constants for the move and compare control block
// Assumes: one synchronous clock, array depth kept small for simulation
// Notes:   op-code fields sit in the low nine bits of the control word
`ifndef CMC_REGS_SVH
`define CMC_REGS_SVH

// op-code field layout
`define CMC_OPC_W      12
`define CMC_OP_HI      5
`define CMC_OP_LO      0
`define CMC_MSEL_HI    8
`define CMC_MSEL_LO    6

// operation field values
`define CMC_OP_W       6
`define CMC_OP_AR      6'h0C
`define CMC_OP_NFA     6'h0D
`define CMC_OP_HPM     6'h0E
`define CMC_OP_CMP     6'h18
`define CMC_OP_CMPBUS  6'h19
`define CMC_OP_CMPWR   6'h1A
`define CMC_OP_NEXT    6'h1B

// widths and depth
`define CMC_WORD_W     64
`define CMC_HALF_W     32
`define CMC_DEPTH      16
`define CMC_AW         4
`define CMC_MA_W       16
`define CMC_MSEL_W     3
`define CMC_MASKS      7
`define CMC_MSEL_NONE  3'h0
`define CMC_MSEL_ONE   3'h1

// reset values
`define CMC_CR_RST     64'h0
`define CMC_NO_MATCH   16'hFFFF
`define CMC_ZERO_WORD  64'h0

`endif

// ===== rtl/cmc_pkg.sv
// Purpose: shared types for the move and compare control block
// Assumes: constants come from cmc_regs.svh
// Notes:   state is one packed struct per module
`include "cmc_regs.svh"

package cmc_pkg;

  typedef logic [`CMC_WORD_W-1:0] cmc_word_t;

  // control-state request presented by the controller each cycle
  typedef struct packed {
    logic [`CMC_OPC_W-1:0]  opcode;
    logic                   write_n;
    logic                   addr_valid_n;
    logic                   data_segment_select;
    logic [`CMC_HALF_W-1:0] dq;
  } cmc_cmd_s;

  typedef struct packed {
    logic [`CMC_DEPTH-1:0][`CMC_WORD_W-1:0] mem;
    logic [`CMC_DEPTH-1:0]                  valid_n;
    logic [`CMC_WORD_W-1:0]                 comparand;
    logic [`CMC_DEPTH-1:0]                  match_vec;
    logic [`CMC_MA_W-1:0]                   match_addr;
  } cmc_state_s;

endpackage : cmc_pkg

// ===== rtl/cmc_masked_merge.sv
// Purpose: masked merge of a source word into a destination word
// Assumes: mask bit low lets the source through
// Notes:   all-zero mask means a plain copy
`timescale 1ns/1ns
`include "cmc_regs.svh"

module cmc_masked_merge (
  input  wire logic [`CMC_WORD_W-1:0] dest,
  input  wire logic [`CMC_WORD_W-1:0] src,
  input  wire logic [`CMC_WORD_W-1:0] mask,
  output logic      [`CMC_WORD_W-1:0] result
);
  assign result = (src & ~mask) | (dest & mask);
endmodule : cmc_masked_merge

// ===== rtl/cmc_prio_enc.sv
// Purpose: lowest-index-first priority encoder
// Assumes: index 0 is the highest priority
// Notes:   idx reads zero when nothing is set
`timescale 1ns/1ns
`include "cmc_regs.svh"

module cmc_prio_enc (
  input  wire logic [`CMC_DEPTH-1:0] vec,
  output logic      [`CMC_AW-1:0]    idx,
  output logic                       found
);
  always_comb begin
    idx   = '0;
    found = 1'b0;
    // scan downward so the lowest set index wins
    for (int i = `CMC_DEPTH - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx   = `CMC_AW'(i);
        found = 1'b1;
      end
    end
  end
endmodule : cmc_prio_enc

// ===== rtl/cmc_move_compare.sv
// Purpose: data-move and compare control states of a 64-bit lookup array
// Assumes: controller runs on clk_sys; all inputs are synchronous to it
// Notes:   array, validity bits and comparand live here; masks and the
//          address register are kept by neighbouring logic
`timescale 1ns/1ns
`include "cmc_regs.svh"

module cmc_move_compare (
  input  wire logic                                  clk_sys,
  input  wire logic                                  rst,
  input  wire cmc_pkg::cmc_cmd_s                     cmd,
  input  wire logic [`CMC_AW-1:0]                    addr_reg,
  input  wire logic [`CMC_MASKS-1:0][`CMC_WORD_W-1:0] mask_bank,
  input  wire logic                                  full_chain_in_n,
  input  wire logic                                  validity_line_n_i,
  output logic                                       validity_line_n_o,
  output logic                                       validity_line_n_oe,
  output logic      [`CMC_MA_W-1:0]                  match_address_bus,
  output logic                                       match_flag_n,
  output logic                                       full_flag_n,
  output logic      [`CMC_WORD_W-1:0]                comparand_out
);

  //////////////////////////////////////////////////////////////////////////
  // decode

  cmc_pkg::cmc_state_s st;
  cmc_pkg::cmc_state_s next_st;

  logic [`CMC_OP_W-1:0]   op;
  logic [`CMC_MSEL_W-1:0] msel;
  logic [`CMC_WORD_W-1:0] mask;
  logic                   ctl;
  logic                   wr_ar;
  logic                   rd_ar;
  logic                   do_nfa;
  logic                   wr_hpm;
  logic                   rd_hpm;
  logic                   do_cmp;
  logic                   do_cmpbus;
  logic                   do_cmpwr;
  logic                   do_next;
  logic                   into_array;
  logic                   into_cr;
  logic                   has_free;
  logic                   has_match;
  logic [`CMC_AW-1:0]     free_idx;
  logic [`CMC_AW-1:0]     top_idx;
  logic [`CMC_AW-1:0]     tgt;
  logic [`CMC_WORD_W-1:0] arr_word;
  logic [`CMC_WORD_W-1:0] arr_new;
  logic [`CMC_WORD_W-1:0] cr_new;
  logic [`CMC_WORD_W-1:0] mixed;
  logic [`CMC_WORD_W-1:0] key;
  logic [`CMC_DEPTH-1:0]  hit;
  logic [`CMC_DEPTH-1:0]  left_vec;
  logic [`CMC_DEPTH-1:0]  enc_in;
  logic [`CMC_AW-1:0]     enc_idx;
  logic                   enc_found;

  assign op   = cmd.opcode[`CMC_OP_HI:`CMC_OP_LO];
  assign msel = cmd.opcode[`CMC_MSEL_HI:`CMC_MSEL_LO];
  assign ctl  = cmd.addr_valid_n;

  assign mask = (msel == `CMC_MSEL_NONE) ? `CMC_ZERO_WORD
              : mask_bank[`CMC_AW'(msel - `CMC_MSEL_ONE)];

  // reserved codes match none of these terms
  assign wr_ar     = ctl && (op == `CMC_OP_AR) && !cmd.write_n;
  assign rd_ar     = ctl && (op == `CMC_OP_AR) && cmd.write_n;
  assign do_nfa    = ctl && (op == `CMC_OP_NFA) && !cmd.write_n
                   && !full_chain_in_n && full_flag_n;
  // top-match moves need a retained match
  assign wr_hpm    = ctl && (op == `CMC_OP_HPM) && !cmd.write_n && has_match;
  assign rd_hpm    = ctl && (op == `CMC_OP_HPM) && cmd.write_n && has_match;
  assign do_cmp    = ctl && (op == `CMC_OP_CMP);
  assign do_cmpbus = ctl && (op == `CMC_OP_CMPBUS);
  assign do_cmpwr  = ctl && (op == `CMC_OP_CMPWR);
  assign do_next   = ctl && (op == `CMC_OP_NEXT);

  assign into_array = wr_ar || do_nfa || wr_hpm;
  assign into_cr    = rd_ar || rd_hpm;

  //////////////////////////////////////////////////////////////////////////
  // target and data paths

  cmc_prio_enc u_free (
    .vec   (st.valid_n),
    .idx   (free_idx),
    .found (has_free)
  );

  cmc_prio_enc u_top (
    .vec   (st.match_vec),
    .idx   (top_idx),
    .found (has_match)
  );

  always_comb begin
    tgt = addr_reg;
    if (do_nfa) begin
      tgt = free_idx;
    end else if (wr_hpm || rd_hpm) begin
      tgt = top_idx;
    end
  end

  assign arr_word = st.mem[tgt];

  cmc_masked_merge u_to_array (
    .dest   (arr_word),
    .src    (st.comparand),
    .mask   (mask),
    .result (arr_new)
  );

  cmc_masked_merge u_to_cr (
    .dest   (st.comparand),
    .src    (arr_word),
    .mask   (mask),
    .result (cr_new)
  );

  // bus half replaces the selected comparand half
  assign mixed = cmd.data_segment_select
               ? {cmd.dq, st.comparand[`CMC_HALF_W-1:0]}
               : {st.comparand[`CMC_WORD_W-1:`CMC_HALF_W], cmd.dq};

  assign key = (do_cmpbus || do_cmpwr) ? mixed : st.comparand;

  // mask-low bits only; valid words only
  always_comb begin
    hit = '0;
    for (int i = 0; i < `CMC_DEPTH; i++) begin
      hit[i] = !st.valid_n[i] && (((st.mem[i] ^ key) & ~mask) == `CMC_ZERO_WORD);
    end
  end

  // drop the reported match, the next one comes up
  always_comb begin
    left_vec = st.match_vec;
    left_vec[top_idx] = 1'b0;
  end

  // one encoder serves both fresh compares and advances
  assign enc_in = (do_cmp || do_cmpbus || do_cmpwr) ? hit : left_vec;

  cmc_prio_enc u_next (
    .vec   (enc_in),
    .idx   (enc_idx),
    .found (enc_found)
  );

  //////////////////////////////////////////////////////////////////////////
  // state update

  always_comb begin
    next_st = st;
    if (into_array) begin
      next_st.mem[tgt] = arr_new;
      next_st.valid_n[tgt] = validity_line_n_i;
      next_st.match_addr = `CMC_MA_W'(tgt);
    end
    if (into_cr) begin
      next_st.comparand = cr_new;
      next_st.match_addr = `CMC_MA_W'(tgt);
    end
    if (do_cmp || do_cmpbus || do_cmpwr || do_next) begin
      // result held until the next compare or advance
      next_st.match_vec = enc_in;
      next_st.match_addr = enc_found ? `CMC_MA_W'(enc_idx) : `CMC_NO_MATCH;
    end
    // unmasked write; compare already used the new value
    if (do_cmpwr) begin
      next_st.comparand = mixed;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st.mem        <= '0;
      st.valid_n    <= '1;
      st.comparand  <= `CMC_CR_RST;
      st.match_vec  <= '0;
      st.match_addr <= `CMC_NO_MATCH;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  // this block never drives the validity line
  assign validity_line_n_o  = 1'b1;
  assign validity_line_n_oe = 1'b0;

  assign match_address_bus = st.match_addr;
  // flag high once no match is left
  assign match_flag_n      = !has_match;
  // full flag high while an empty word remains
  assign full_flag_n       = has_free;
  assign comparand_out     = st.comparand;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  store_copy_a: assert property (
    wr_ar && msel == `CMC_MSEL_NONE |=> st.mem[$past(addr_reg)] == $past(st.comparand))
    else $error("comparand not stored at address register");

  store_valid_a: assert property (
    into_array |=> st.valid_n[$past(tgt)] == $past(validity_line_n_i))
    else $error("validity bit not taken from line");

  masked_keep_a: assert property (
    wr_ar |=> ((st.mem[$past(addr_reg)] ^ $past(arr_word)) & $past(mask)) == '0)
    else $error("masked bits of target changed");

  load_copy_a: assert property (
    rd_ar && msel == `CMC_MSEL_NONE |=> comparand_out == $past(arr_word))
    else $error("comparand not loaded from array");

  vb_undriven_a: assert property (
    into_cr |-> !validity_line_n_oe)
    else $error("validity line driven during load");

  free_addr_a: assert property (
    do_nfa |=> match_address_bus == `CMC_MA_W'($past(free_idx)))
    else $error("free address not shown");

  free_gate_a: assert property (
    ctl && op == `CMC_OP_NFA && (full_chain_in_n || !full_flag_n)
      |=> st.mem == $past(st.mem))
    else $error("free store while gated off");

  cmp_flag_a: assert property (
    do_cmp |=> match_flag_n == !(|$past(hit)))
    else $error("match flag wrong after compare");

  bus_cr_keep_a: assert property (
    do_cmpbus |=> $stable(comparand_out))
    else $error("composite compare changed comparand");

  wr_half_a: assert property (
    do_cmpwr && !cmd.data_segment_select
      |=> comparand_out[`CMC_HALF_W-1:0] == $past(cmd.dq))
    else $error("write-and-compare write not unmasked");

  next_step_a: assert property (
    do_next && has_match
      |=> $countones(st.match_vec) == $countones($past(st.match_vec)) - 1)
    else $error("advance did not drop one match");

  exhaust_a: assert property (
    do_next && $countones(st.match_vec) == 1 |=> match_flag_n ##1 1)
    else $error("match flag low after last match");

  hold_top_a: assert property (
    !(do_cmp || do_cmpbus || do_cmpwr || do_next) |=> $stable(st.match_vec))
    else $error("match result lost");

  hpm_store_a: assert property (
    wr_hpm && msel == `CMC_MSEL_NONE |=> st.mem[$past(top_idx)] == $past(st.comparand))
    else $error("comparand not stored at top match");

  hpm_load_a: assert property (
    rd_hpm |=> (((comparand_out ^ st.mem[$past(top_idx)]) & ~$past(mask)) == '0)
      && (((comparand_out ^ $past(st.comparand)) & $past(mask)) == '0))
    else $error("comparand not loaded from top match");

  bus_cmp_flag_a: assert property (
    do_cmpbus |=> match_flag_n == !(|$past(hit)))
    else $error("match flag wrong after composite compare");

  cmp_wr_flag_a: assert property (
    do_cmpwr |=> match_flag_n == !(|$past(hit)))
    else $error("match flag wrong after write and compare");

  cmp_unmasked_a: assert property (
    (do_cmp || do_cmpbus || do_cmpwr) && (|hit)
      |=> ((st.mem[match_address_bus[`CMC_AW-1:0]] ^ $past(key)) & ~$past(mask)) == '0)
    else $error("reported word differs in compared bits");

  cmp_valid_a: assert property (
    (do_cmp || do_cmpbus || do_cmpwr) && (|hit)
      |=> !st.valid_n[match_address_bus[`CMC_AW-1:0]])
    else $error("empty word reported as match");

  wr_upper_a: assert property (
    do_cmpwr && cmd.data_segment_select
      |=> comparand_out[`CMC_WORD_W-1:`CMC_HALF_W] == $past(cmd.dq)
      && $stable(comparand_out[`CMC_HALF_W-1:0]))
    else $error("write-and-compare upper half wrong");

  hpm_addr_a: assert property (
    wr_hpm || rd_hpm |=> match_address_bus == `CMC_MA_W'($past(top_idx)))
    else $error("top match address not shown");

  idle_keep_a: assert property (
    !(into_array || into_cr || do_cmp || do_cmpbus || do_cmpwr || do_next) |=> $stable(st))
    else $error("state changed on an ignored cycle");

  multi_c: cover property (do_cmp ##1 $countones(st.match_vec) > 1);
  next_c:  cover property (do_next && $countones(st.match_vec) > 1);
  free_c:  cover property (do_nfa ##1 do_cmp);
  walk_c:  cover property (do_cmpwr ##1 do_next ##1 match_flag_n);
  hpm_c:   cover property (wr_hpm ##1 rd_hpm);

endmodule : cmc_move_compare

// ===== testbench/cmc_ctrl_model.sv
// Purpose: controller model driving the move and compare control states
// Assumes: called at the falling edge; holds its request through the next rise
// Notes:   idle cycles drop addr_valid_n and toggle the data bus
`timescale 1ns/1ns
`include "cmc_regs.svh"

module cmc_ctrl_model (
  input  wire logic                                  clk_sys,
  output cmc_pkg::cmc_cmd_s                          cmd,
  output logic [`CMC_AW-1:0]                         addr_reg,
  output logic [`CMC_MASKS-1:0][`CMC_WORD_W-1:0]     mask_bank,
  output logic                                       full_chain_in_n,
  output logic                                       validity_line_n_i
);
  initial begin
    cmd               = '0;
    addr_reg          = '0;
    mask_bank         = '0;
    full_chain_in_n   = 1'b1;
    validity_line_n_i = 1'b1;
  end

  task automatic send(input logic [5:0] op, input logic [2:0] ms, input logic w_n,
                      input logic dss, input logic [31:0] dq, input logic [3:0] ar,
                      input logic vb);
    // top bits random, ignored by device
    cmd.opcode = {3'($urandom), ms, op};
    cmd.write_n = w_n;
    // addr valid high on every op
    cmd.addr_valid_n = 1'b1;
    // segment select low outside bus compares
    cmd.data_segment_select = (op == 6'h19 || op == 6'h1A) ? dss : 1'b0;
    cmd.dq = dq;
    addr_reg = ar;
    validity_line_n_i = vb;
  endtask : send

  // released bus shows a changing pattern, never the last value
  task automatic idle();
    cmd.addr_valid_n = 1'b0;
    cmd.dq = ~cmd.dq;
    validity_line_n_i = ~validity_line_n_i;
  endtask : idle
endmodule : cmc_ctrl_model

// ===== testbench/cmc_move_compare_tb.sv
// Purpose: self-checking bench for the move and compare block
// Assumes: reference model below is written from the control-state rules
// Notes:   array contents are seen only through loads into the comparand and through compare results
`timescale 1ns/1ns
`include "cmc_regs.svh"

module cmc_move_compare_tb;
  logic              clk_sys;
  logic              rst;
  cmc_pkg::cmc_cmd_s cmd;
  logic [3:0]        addr_reg;
  logic [6:0][63:0]  mask_bank;
  logic              full_chain_in_n;
  logic              vb_i;
  logic              vb_o;
  logic              vb_oe;
  logic [15:0]       match_address_bus;
  logic              match_flag_n;
  logic              full_flag_n;
  logic [63:0]       comparand_out;
  logic [63:0]       m_mem[16];
  logic [15:0]       m_vn;
  logic [15:0]       m_mv;
  logic [15:0]       m_bus;
  logic [63:0]       m_cr;
  int                num_errors;
  int                checked;
  logic [5:0]        ops[8] = '{6'h0C, 6'h0D, 6'h0E, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h3F};

  cmc_ctrl_model ctrl_inst (.clk_sys(clk_sys), .cmd(cmd), .addr_reg(addr_reg),
    .mask_bank(mask_bank), .full_chain_in_n(full_chain_in_n), .validity_line_n_i(vb_i));

  cmc_move_compare cmc_move_compare_inst (.clk_sys(clk_sys), .rst(rst), .cmd(cmd),
    .addr_reg(addr_reg), .mask_bank(mask_bank), .full_chain_in_n(full_chain_in_n),
    .validity_line_n_i(vb_i), .validity_line_n_o(vb_o), .validity_line_n_oe(vb_oe),
    .match_address_bus(match_address_bus), .match_flag_n(match_flag_n),
    .full_flag_n(full_flag_n), .comparand_out(comparand_out));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] seen);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  function automatic logic [15:0] first(input logic [15:0] v);
    first = 16'hFFFF;
    for (int i = 15; i >= 0; i--)
      if (v[i]) first = 16'(i);
  endfunction : first

  // mask bit low lets the source through
  function automatic logic [63:0] mrg(input logic [63:0] d, input logic [63:0] s,
                                      input logic [63:0] mk);
    mrg = (d & mk) | (s & ~mk);
  endfunction : mrg

  task automatic wr(input logic [15:0] idx, input logic [63:0] mk, input logic vb);
    m_mem[idx[3:0]] = mrg(m_mem[idx[3:0]], m_cr, mk);
    m_vn[idx[3:0]] = vb;
    m_bus = idx;
  endtask : wr

  // issue one op at the falling edge, update model, check one cycle later
  task automatic step(input logic [5:0] op, input logic [2:0] ms, input logic w_n,
                      input logic dss, input logic [31:0] dq, input logic [3:0] ar,
                      input logic vb);
    logic [63:0] mk;
    logic [63:0] key;
    logic [15:0] hit;
    ctrl_inst.send(op, ms, w_n, dss, dq, ar, vb);
    mk = (ms == 3'h0) ? 64'h0 : mask_bank[ms - 3'h1];
    key = cmd.data_segment_select ? {dq, m_cr[31:0]} : {m_cr[63:32], dq};
    hit = '0;
    case (op)
      6'h0C: if (!w_n) wr(16'(ar), mk, vb);
             else begin
               m_cr = mrg(m_cr, m_mem[ar], mk);
               m_bus = 16'(ar);
             end
      6'h0D: if (!w_n && !full_chain_in_n && m_vn != 16'h0) wr(first(m_vn), mk, vb);
      6'h0E: if (m_mv != 16'h0) begin
               if (!w_n) wr(first(m_mv), mk, vb);
               else m_cr = mrg(m_cr, m_mem[first(m_mv)], mk);
               m_bus = first(m_mv);
             end
      6'h18, 6'h19, 6'h1A: begin
        if (op == 6'h18) key = m_cr;
        if (op == 6'h1A) m_cr = key;
        for (int i = 0; i < 16; i++)
          hit[i] = !m_vn[i] && (((m_mem[i] ^ key) & ~mk) == 64'h0);
        m_mv = hit;
        m_bus = first(hit);
      end
      6'h1B: begin
        m_mv = m_mv & (m_mv - 16'h1);
        m_bus = first(m_mv);
      end
      default: ;
    endcase
    @(negedge clk_sys);
    check("comparand", m_cr, comparand_out);
    check("match_bus", 64'(m_bus), 64'(match_address_bus));
    check("match_flag", 64'(m_mv == 16'h0), 64'(match_flag_n));
    check("full_flag", 64'(m_vn != 16'h0), 64'(full_flag_n));
    check("vb_enable", 64'h0, 64'(vb_oe));
    check("vb_level", 64'h1, 64'(vb_o));
  endtask : step

  initial begin
    repeat (30000) @(posedge clk_sys);
    num_errors++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    num_errors = 0;
    checked = 0;
    rst = 1'b1;
    void'($urandom(32'h22eaded9));
    m_vn = 16'hFFFF;
    m_mv = 16'h0;
    m_bus = 16'hFFFF;
    m_cr = 64'h0;
    foreach (m_mem[i]) m_mem[i] = 64'h0;
    repeat (12) @(posedge clk_sys);
    // masks set after time zero so the model's start-up clear cannot win the race
    for (int i = 0; i < 7; i++)
      ctrl_inst.mask_bank[i] = {$urandom, $urandom} & {$urandom, $urandom};
    @(negedge clk_sys);
    rst = 1'b0;
    // fill every free word, then one more store is refused
    ctrl_inst.full_chain_in_n = 1'b0;
    for (int i = 0; i < 17; i++) begin
      step(6'h1A, 3'h0, 1'b0, i[0], 32'(i % 3), 4'h0, 1'b0);
      step(6'h0D, 3'(i % 8), 1'b0, 1'b0, 32'h0, 4'h0, 1'b0);
    end
    // random mix of all codes, masks, segments and chain input
    for (int n = 0; n < 400; n++) begin
      ctrl_inst.full_chain_in_n = ($urandom_range(0, 3) == 0);
      step(ops[$urandom_range(0, 7)], 3'($urandom_range(0, 7)), 1'($urandom),
           1'($urandom), 32'($urandom_range(0, 3)), 4'($urandom), 1'($urandom_range(0, 3) == 0));
      if ($urandom_range(0, 3) == 0) begin
        ctrl_inst.idle();
        @(negedge clk_sys);
        check("idle_bus", 64'(m_bus), 64'(match_address_bus));
      end
    end
    tally_and_finish();
  end
endmodule : cmc_move_compare_tb
